/* logic/kdc_pkg.sv */
// kdc_pkg: constants, register map and message codes of the keypad/display controller
// assumes a 20 MHz clock and an APB master with 32-bit data
package kdc_pkg;
  localparam int CLK_HZ = 20_000_000;
  localparam int VER_MS = 2000;
  localparam int ACK_MS = 1000;
  localparam int DEB_MS = 10;
  localparam int REP_MS = 50;
  localparam int VER_CYC = CLK_HZ / 1000 * VER_MS;
  localparam int ACK_CYC = CLK_HZ / 1000 * ACK_MS;
  localparam int DEB_CYC = CLK_HZ / 1000 * DEB_MS;
  localparam int REP_CYC = CLK_HZ / 1000 * REP_MS;
  localparam int TMR_W = 26;
  localparam int NPARAM = 16;
  localparam int IDX_W = 4;
  localparam int VAL_W = 16;
  localparam int MSG_W = 4;
  localparam int AW = 8;
  localparam logic [IDX_W-1:0] IDX_SPEED_SLOT = 4'h0;
  localparam logic [IDX_W-1:0] IDX_POS = 4'h1;
  localparam logic [IDX_W-1:0] IDX_CUR = 4'h2;
  localparam logic [IDX_W-1:0] IDX_BIT_LO = 4'ha;
  localparam logic [IDX_W-1:0] IDX_SBIT_LO = 4'hc;
  localparam logic [IDX_W-1:0] IDX_INS_LO = 4'he;
  localparam logic [VAL_W-1:0] POS_MASK = 16'h0fff;
  localparam logic [VAL_W-1:0] CUR_MAX = 16'h03e8;
  localparam logic [VAL_W-1:0] STEP = 16'h0001;
  localparam logic [VAL_W-1:0] FAST_STEP = 16'h000a;
  localparam logic [MSG_W-1:0] MSG_VERSION = 4'h0;
  localparam logic [MSG_W-1:0] MSG_IDLE = 4'h1;
  localparam logic [MSG_W-1:0] MSG_RUN = 4'h2;
  localparam logic [MSG_W-1:0] MSG_ALARM = 4'h3;
  localparam logic [MSG_W-1:0] MSG_BUS_LOW = 4'h4;
  localparam logic [MSG_W-1:0] MSG_DEC_LABEL = 4'h5;
  localparam logic [MSG_W-1:0] MSG_BIT_LABEL = 4'h6;
  localparam logic [MSG_W-1:0] MSG_SBIT_LABEL = 4'h7;
  localparam logic [MSG_W-1:0] MSG_INS_LABEL = 4'h8;
  localparam logic [MSG_W-1:0] MSG_VALUE = 4'h9;
  localparam logic [MSG_W-1:0] MSG_BIT_STATE = 4'ha;
  localparam logic [MSG_W-1:0] MSG_DONE = 4'hb;
  localparam logic [MSG_W-1:0] MSG_RESET = 4'hc;
  localparam logic [MSG_W-1:0] MSG_TEST = 4'hd;
  localparam logic [MSG_W-1:0] MSG_RETRY = 4'he;
  localparam logic [AW-1:0] OFF_CTRL = 8'h00;
  localparam logic [AW-1:0] OFF_CMD = 8'h04;
  localparam logic [AW-1:0] OFF_STATUS = 8'h08;
  localparam logic [AW-1:0] OFF_VALUE = 8'h0c;
  localparam logic [AW-1:0] OFF_IRQ_STAT = 8'h10;
  localparam logic [AW-1:0] OFF_IRQ_EN = 8'h14;
  localparam logic [AW-1:0] OFF_IRQ_CLR = 8'h18;
  localparam logic [AW-1:0] OFF_VERSION = 8'h1c;
  localparam int B_LOWV = 0;
  localparam int B_WIRE = 1;
  localparam int B_CLR = 0;
  localparam int B_PSTORE = 1;
  localparam int B_SSAVE = 2;
  localparam int B_OTHER = 3;
  localparam int NIRQ = 4;
  typedef enum logic [1:0] {V_SEL = 2'b01, V_VAL = 2'b10} kdc_view_t;
endpackage

/* logic/kdc_top.sv */
// kdc_top: three-key keypad and display controller with APB registers
// assumes keys and drive flags synchronous to REF_CLK, keys high while pressed
`timescale 1ns/1ps
`default_nettype none
module kdc_debounce
#(
  parameter int CNT = kdc_pkg::DEB_CYC
)
(
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic raw,
  output logic      level
);
  import kdc_pkg::*;
  logic [TMR_W-1:0] cnt;
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      level <= 1'b0;
      cnt   <= '0;
    end
    else if (raw == level)
      cnt <= '0;
    else if (cnt == TMR_W'(CNT - 1))
    begin
      level <= raw;
      cnt   <= '0;
    end
    else
      cnt <= cnt + 1'b1;
  end
endmodule

module kdc_top
#(
  parameter int VER_N = kdc_pkg::VER_CYC,
  parameter int ACK_N = kdc_pkg::ACK_CYC,
  parameter int DEB_N = kdc_pkg::DEB_CYC,
  parameter int REP_N = kdc_pkg::REP_CYC,
  parameter logic [15:0] SW_VERSION = 16'h0012 // arbitrary value
)
(
  // clock and reset
  input  wire logic                      REF_CLK,
  input  wire logic                      RST_B,
  // apb slave
  input  wire logic                      PSEL,
  input  wire logic                      PENABLE,
  input  wire logic                      PWRITE,
  input  wire logic [kdc_pkg::AW-1:0]    PADDR,
  input  wire logic [31:0]               PWDATA,
  output logic      [31:0]               PRDATA,
  output logic                           PREADY,
  output logic                           PSLVERR,
  // keypad
  input  wire logic                      KEY_MODE,
  input  wire logic                      KEY_UP,
  input  wire logic                      KEY_DOWN,
  // drive flags
  input  wire logic                      ALARM,
  input  wire logic [7:0]                ALARM_CODE,
  input  wire logic                      DRIVE_EN,
  input  wire logic                      BUS_ABOVE_TH,
  input  wire logic                      STORE_ERR,
  output logic                           DRIVE_DISABLE,
  output logic                           BUS_READY,
  output logic                           ALARM_CLEAR,
  // display
  output logic      [kdc_pkg::MSG_W-1:0] DISP_MSG,
  output logic      [kdc_pkg::VAL_W-1:0] DISP_DATA,
  output logic                           IRQ
);
  import kdc_pkg::*;

  logic              mode_lvl, up_lvl, dn_lvl;
  logic              mode_q, up_q, dn_q;
  logic              mode_ev, up_ev, dn_ev, mode_tog;
  logic              fast, rep_tick, fast_go, edit_ok;
  logic [TMR_W-1:0]  rep_cnt, ver_cnt, ack_cnt;
  kdc_view_t         view;
  logic [IDX_W-1:0]  idx;
  logic [VAL_W-1:0]  params [NPARAM];
  logic [VAL_W-1:0]  cur_val;
  logic              alarm_q, alarm_rise, alarm_lat;
  logic [7:0]        alarm_code;
  logic              ack_rst, retry, err_q;
  logic [1:0]        ctrl;
  logic              apb_wr, apb_acc, cmd_wr, clr_cmd, any_cmd;
  logic [NIRQ-1:0]   irq_stat, irq_en, irq_ev;
  logic              slot0;
  logic [MSG_W-1:0]  next_msg;
  logic [VAL_W-1:0]  next_data;
  logic [31:0]       next_rdata;
  logic              next_err;

  // one debouncer per key
  kdc_debounce #(.CNT(DEB_N)) u_deb_mode (.clk(REF_CLK), .rst_b(RST_B), .raw(KEY_MODE), .level(mode_lvl));
  kdc_debounce #(.CNT(DEB_N)) u_deb_up (.clk(REF_CLK), .rst_b(RST_B), .raw(KEY_UP), .level(up_lvl));
  kdc_debounce #(.CNT(DEB_N)) u_deb_dn (.clk(REF_CLK), .rst_b(RST_B), .raw(KEY_DOWN), .level(dn_lvl));

  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      mode_q <= 1'b0;
      up_q   <= 1'b0;
      dn_q   <= 1'b0;
    end
    else
    begin
      mode_q <= mode_lvl;
      up_q   <= up_lvl;
      dn_q   <= dn_lvl;
    end
  end

  assign mode_ev = mode_lvl & ~mode_q;
  assign up_ev = up_lvl & ~up_q;
  assign dn_ev = dn_lvl & ~dn_q;
  assign mode_tog = mode_ev & ~up_lvl & ~dn_lvl;

  // fast stepping armed by mode while an adjust key is held
  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
      fast <= 1'b0;
    else if (!up_lvl && !dn_lvl)
      fast <= 1'b0;
    else if (mode_ev)
      fast <= 1'b1;
  end

  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      rep_cnt  <= '0;
      rep_tick <= 1'b0;
    end
    else if (rep_cnt == TMR_W'(REP_N - 1))
    begin
      rep_cnt  <= '0;
      rep_tick <= 1'b1;
    end
    else
    begin
      rep_cnt  <= rep_cnt + 1'b1;
      rep_tick <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
      view <= V_SEL;
    else if (alarm_rise)
      view <= V_SEL;
    else if (mode_tog)
    begin
      case (view)
        V_SEL: view <= V_VAL;
        V_VAL: view <= V_SEL;
        default: view <= V_SEL;
      endcase
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
      idx <= IDX_SPEED_SLOT;
    else if (alarm_rise)
      idx <= IDX_SPEED_SLOT;
    else if (view == V_SEL && up_ev && !dn_lvl)
      idx <= idx + 1'b1;
    else if (view == V_SEL && dn_ev && !up_lvl)
      idx <= idx - 1'b1;
  end

  function automatic logic [VAL_W-1:0] f_step(input logic [IDX_W-1:0] i, input logic [VAL_W-1:0] v,
                                              input logic [VAL_W-1:0] d, input logic up);
    logic [VAL_W-1:0] r;
    r = up ? v + d : v - d;
    if (i == IDX_POS)
      r = r & POS_MASK;
    else if (i == IDX_CUR && r > CUR_MAX)
      r = up ? CUR_MAX : '0;
    return r;
  endfunction

  assign cur_val = params[idx];
  assign edit_ok = (view == V_VAL) && (idx != IDX_SPEED_SLOT);
  assign fast_go = edit_ok & fast & rep_tick & (up_lvl ^ dn_lvl);

  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      for (int i = 0; i < NPARAM; i++)
        params[i] <= '0;
    end
    else if (apb_wr && PADDR == OFF_VALUE)
      params[idx] <= PWDATA[VAL_W-1:0];
    else if (edit_ok && !fast && up_ev && !dn_lvl)
      params[idx] <= f_step(idx, cur_val, STEP, 1'b1);
    else if (edit_ok && !fast && dn_ev && !up_lvl)
      params[idx] <= f_step(idx, cur_val, STEP, 1'b0);
    else if (fast_go)
      params[idx] <= f_step(idx, cur_val, FAST_STEP, up_lvl);
  end

  // drive flags and commands
  assign alarm_rise = ALARM & ~alarm_q;
  assign apb_wr = PSEL & PENABLE & PREADY & PWRITE;
  assign cmd_wr = apb_wr && PADDR == OFF_CMD;
  assign clr_cmd = cmd_wr & PWDATA[B_CLR];
  assign any_cmd = cmd_wr & (PWDATA[B_PSTORE] | PWDATA[B_SSAVE] | PWDATA[B_OTHER]);

  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      alarm_q    <= 1'b0;
      alarm_lat  <= 1'b0;
      alarm_code <= 8'h00;
    end
    else
    begin
      alarm_q <= ALARM;
      if (ALARM)
        alarm_lat <= 1'b1;
      else if (clr_cmd)
        alarm_lat <= 1'b0;
      if (alarm_rise)
        alarm_code <= ALARM_CODE;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      ver_cnt <= TMR_W'(VER_N);
      ack_cnt <= '0;
      ack_rst <= 1'b0;
    end
    else
    begin
      if (ver_cnt != '0)
        ver_cnt <= ver_cnt - 1'b1;
      if (clr_cmd)
      begin
        ack_cnt <= TMR_W'(ACK_N);
        ack_rst <= 1'b1;
      end
      else if (any_cmd)
      begin
        ack_cnt <= TMR_W'(ACK_N);
        ack_rst <= 1'b0;
      end
      else if (ack_cnt != '0)
        ack_cnt <= ack_cnt - 1'b1;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      retry <= 1'b0;
      err_q <= 1'b0;
    end
    else
    begin
      err_q <= STORE_ERR;
      if (STORE_ERR)
        retry <= 1'b1;
      else if (cmd_wr)
        retry <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      BUS_READY   <= 1'b0;
      ALARM_CLEAR <= 1'b0;
    end
    else
    begin
      BUS_READY   <= ctrl[B_LOWV] | BUS_ABOVE_TH;
      ALARM_CLEAR <= clr_cmd;
    end
  end

  assign DRIVE_DISABLE = alarm_lat;

  // display selection in priority order
  assign slot0 = (view == V_SEL) && (idx == IDX_SPEED_SLOT);

  always_comb
  begin
    next_msg  = MSG_VALUE;
    next_data = cur_val;
    if (ver_cnt != '0)
    begin
      next_msg  = MSG_VERSION;
      next_data = SW_VERSION;
    end
    else if (alarm_lat && slot0)
    begin
      next_msg  = MSG_ALARM;
      next_data = {8'h00, alarm_code};
    end
    else if (ctrl[B_WIRE])
      next_msg = MSG_TEST;
    else if (retry)
      next_msg = MSG_RETRY;
    else if (ack_cnt != '0)
      next_msg = ack_rst ? MSG_RESET : MSG_DONE;
    else if (slot0)
    begin
      next_data = '0;
      if (!ctrl[B_LOWV] && !BUS_ABOVE_TH)
        next_msg = MSG_BUS_LOW;
      else
        next_msg = DRIVE_EN ? MSG_RUN : MSG_IDLE;
    end
    else if (view == V_SEL)
    begin
      next_data = {{(VAL_W-IDX_W){1'b0}}, idx};
      if (idx < IDX_BIT_LO)
        next_msg = MSG_DEC_LABEL;
      else if (idx < IDX_SBIT_LO)
        next_msg = MSG_BIT_LABEL;
      else if (idx < IDX_INS_LO)
        next_msg = MSG_SBIT_LABEL;
      else
        next_msg = MSG_INS_LABEL;
    end
    else if (idx >= IDX_SBIT_LO && idx < IDX_INS_LO)
    begin
      next_msg  = MSG_BIT_STATE;
      next_data = {{(VAL_W-1){1'b0}}, cur_val[0]};
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      DISP_MSG  <= MSG_VERSION;
      DISP_DATA <= '0;
    end
    else
    begin
      DISP_MSG  <= next_msg;
      DISP_DATA <= next_data;
    end
  end

  // interrupts: alarm, key press, store error, version end
  assign irq_ev = {ver_cnt == TMR_W'(1), STORE_ERR & ~err_q, mode_ev | up_ev | dn_ev, alarm_rise};

  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      irq_stat <= '0;
      irq_en   <= '0;
      IRQ      <= 1'b0;
    end
    else
    begin
      if (apb_wr && PADDR == OFF_IRQ_CLR)
        irq_stat <= (irq_stat & ~PWDATA[NIRQ-1:0]) | irq_ev;
      else
        irq_stat <= irq_stat | irq_ev;
      if (apb_wr && PADDR == OFF_IRQ_EN)
        irq_en <= PWDATA[NIRQ-1:0];
      IRQ <= |(irq_stat & irq_en);
    end
  end

  // apb: one wait state, read data latched on first access edge, write data taken on the pready edge
  assign apb_acc = PSEL & PENABLE & ~PREADY;

  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
      ctrl <= '0;
    else if (apb_wr && PADDR == OFF_CTRL)
      ctrl <= PWDATA[1:0];
  end

  always_comb
  begin
    next_rdata = '0;
    next_err   = 1'b0;
    if (PADDR == OFF_CTRL)
      next_rdata = {30'h0, ctrl};
    else if (PADDR == OFF_CMD)
      next_rdata = '0;
    else if (PADDR == OFF_STATUS)
      next_rdata = {20'h0, DISP_MSG, idx, fast, BUS_READY, alarm_lat, view == V_VAL};
    else if (PADDR == OFF_VALUE)
      next_rdata = {16'h0, cur_val};
    else if (PADDR == OFF_IRQ_STAT)
      next_rdata = {28'h0, irq_stat};
    else if (PADDR == OFF_IRQ_EN)
      next_rdata = {28'h0, irq_en};
    else if (PADDR == OFF_IRQ_CLR)
      next_rdata = '0;
    else if (PADDR == OFF_VERSION)
      next_rdata = {16'h0, SW_VERSION};
    else
      next_err = 1'b1;
  end

  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      PREADY  <= 1'b0;
      PRDATA  <= '0;
      PSLVERR <= 1'b0;
    end
    else
    begin
      PREADY  <= apb_acc;
      PRDATA  <= apb_acc && !PWRITE ? next_rdata : 32'h0;
      PSLVERR <= apb_acc & next_err;
    end
  end

  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RST_B);

  a_mode_toggle: assert property (mode_tog && !alarm_rise |=> view != $past(view))
    else $error("mode press did not toggle view");
  a_sel_step: assert property (view == V_SEL && up_ev && !dn_lvl && !alarm_rise |=> idx == $past(idx) + 1'b1)
    else $error("index did not step up");
  a_val_shown: assert property (DISP_MSG == MSG_VALUE |-> DISP_DATA == $past(cur_val))
    else $error("value view shows wrong data");
  a_alarm_force: assert property (alarm_rise |=> idx == IDX_SPEED_SLOT && view == V_SEL && DRIVE_DISABLE)
    else $error("alarm did not force slot 0");
  a_bus_low: assert property (!ctrl[B_LOWV] && !BUS_ABOVE_TH |=> !BUS_READY)
    else $error("bus ready set under threshold");
  a_version_first: assert property (ver_cnt != '0 |=> DISP_MSG == MSG_VERSION)
    else $error("version message not shown");
  a_ack_reset: assert property (clr_cmd && !ALARM |=> ack_rst && ack_cnt == TMR_W'(ACK_N) ##1 !alarm_lat)
    else $error("reset message not started");
  a_alarm_prio: assert property (alarm_lat && slot0 && ver_cnt == '0 |=> DISP_MSG == MSG_ALARM)
    else $error("alarm message lost priority");
  a_test_msg: assert property (ctrl[B_WIRE] && ver_cnt == '0 && !(alarm_lat && slot0) |=> DISP_MSG == MSG_TEST)
    else $error("test message not shown");
  a_fast_step: assert property (fast_go && up_lvl && idx == IDX_POS && !apb_wr && !alarm_rise
                                |=> cur_val == (($past(cur_val) + FAST_STEP) & POS_MASK))
    else $error("fast step missing");

  c_fast_edit: cover property (fast_go);
  c_alarm_clear: cover property (alarm_lat ##1 clr_cmd);
  c_value_view: cover property (view == V_SEL ##1 view == V_VAL);
  c_retry: cover property (DISP_MSG == MSG_RETRY);
endmodule
`default_nettype wire

/* testbench/kdc_operator.sv */
// kdc_operator: behavioural operator pressing the three front-panel keys
// assumes the bench clock; every press is followed by a full release
`timescale 1ns/1ps
`default_nettype none
module kdc_operator
(
  // clock
  input  wire logic clk,
  // keys, high while pressed
  output logic      key_mode,
  output logic      key_up,
  output logic      key_down
);
  logic [2:0] keys = 3'h0;
  assign key_mode = keys[0];
  assign key_up   = keys[1];
  assign key_down = keys[2];
  // one clean press of key k: 0 mode, 1 up, 2 down
  task automatic tap(input int k, input int hold);
    @(posedge clk);
    keys <= 3'(1 << k);
    repeat (hold) @(posedge clk);
    keys <= 3'h0;
    repeat (hold) @(posedge clk);
  endtask
  // adjust key held while mode is tapped
  task automatic fast(input int k, input int hold);
    @(posedge clk);
    keys <= 3'(1 << k);
    repeat (8) @(posedge clk);
    keys <= 3'(1 << k) | 3'h1;
    repeat (8) @(posedge clk);
    keys <= 3'(1 << k);
    repeat (hold) @(posedge clk);
    keys <= 3'h0;
    repeat (8) @(posedge clk);
  endtask
endmodule
`default_nettype wire

/* testbench/tb_top.sv */
// tb_top: self-checking bench of the keypad/display controller
// assumes kdc_top under logic/ and the operator model beside this file
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import kdc_pkg::*;
  localparam int VN = 50;
  localparam int AN = 30;
  localparam int DN = 3;
  localparam int RN = 8;
  localparam logic [15:0] VERS = 16'h0a5c; // arbitrary value
  logic          clk;
  logic          rst_b;
  logic          psel;
  logic          penable;
  logic          pwrite;
  logic [AW-1:0] paddr;
  logic [31:0]   pwdata;
  logic [31:0]   prdata;
  logic          pready;
  logic          pslverr;
  logic          k_mode;
  logic          k_up;
  logic          k_down;
  logic          alarm;
  logic [7:0]    alarm_code;
  logic          drive_en;
  logic          bus_hi;
  logic          store_err;
  logic          drive_dis;
  logic          bus_ready;
  logic          alarm_clr;
  logic [3:0]    disp_msg;
  logic [15:0]   disp_data;
  logic          irq;
  int            n_mismatch;
  int            cmp_count;
  int            m_idx;
  int            m_view;
  int            m_alarm;
  int            m_val [16];
  int            cnt;
  logic [15:0]   rnd;
  logic [31:0]   rd_q;
  logic          err_q;

  kdc_top #(.VER_N(VN), .ACK_N(AN), .DEB_N(DN), .REP_N(RN), .SW_VERSION(VERS)) u_dut
  (
    .REF_CLK(clk), .RST_B(rst_b),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .KEY_MODE(k_mode), .KEY_UP(k_up), .KEY_DOWN(k_down),
    .ALARM(alarm), .ALARM_CODE(alarm_code), .DRIVE_EN(drive_en), .BUS_ABOVE_TH(bus_hi),
    .STORE_ERR(store_err), .DRIVE_DISABLE(drive_dis), .BUS_READY(bus_ready), .ALARM_CLEAR(alarm_clr),
    .DISP_MSG(disp_msg), .DISP_DATA(disp_data), .IRQ(irq)
  );

  kdc_operator u_op (.clk(clk), .key_mode(k_mode), .key_up(k_up), .key_down(k_down));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic logic [3:0] exp_msg();
    if (m_view != 0)
      return (m_idx >= 12 && m_idx < 14) ? MSG_BIT_STATE : MSG_VALUE;
    if (m_idx == 0)
      return m_alarm != 0 ? MSG_ALARM : drive_en ? MSG_RUN : MSG_IDLE;
    return m_idx < 10 ? MSG_DEC_LABEL : m_idx < 12 ? MSG_BIT_LABEL : m_idx < 14 ? MSG_SBIT_LABEL : MSG_INS_LABEL;
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    if (n_mismatch == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // one apb transfer; read data and error taken at the pready edge
  task automatic apb(input logic w, input logic [AW-1:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
      n_mismatch++;
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic view_chk();
    apb(1'b0, OFF_STATUS, 32'h0);
    chk(32'(rd_q[7:4]), 32'(m_idx));
    chk(32'(rd_q[0]), 32'(m_view));
    @(negedge clk);
    chk(32'(disp_msg), 32'(exp_msg()));
    if (m_view != 0 && m_idx < 12)
      chk(32'(disp_data), 32'(m_val[m_idx]));
    else if (m_view != 0 && m_idx < 14)
      chk(32'(disp_data), 32'(m_val[m_idx] & 1));
    else if (m_view == 0 && m_idx != 0)
      chk(32'(disp_data), 32'(m_idx));
  endtask

  // model of one key press, then compare
  task automatic key(input int k);
    int d;
    u_op.tap(k, 2 * DN);
    d = (k == 1) ? 1 : -1;
    if (k == 0)
      m_view = 1 - m_view;
    else if (m_view == 0)
      m_idx = m_idx + d;
    else if (m_idx == 1)
      m_val[1] = (m_val[1] + d) & 32'h0fff;
    else if (m_idx == 2)
      m_val[2] = (m_val[2] + d > 1000) ? 1000 : (m_val[2] + d < 0) ? 0 : m_val[2] + d;
    view_chk();
  endtask

  initial
  begin
    repeat (30000) @(posedge clk);
    n_mismatch++;
    report_and_stop();
  end

  initial
  begin
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = 32'h0;
    alarm = 1'b0;
    alarm_code = 8'h00;
    drive_en = 1'b0;
    bus_hi = 1'b1;
    store_err = 1'b0;
    n_mismatch = 0;
    cmp_count = 0;
    m_idx = 0;
    m_view = 0;
    m_alarm = 0;
    rnd = 16'h000d;
    foreach (m_val[i]) m_val[i] = 0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    wt(VN - 10);
    chk(32'(disp_msg), 32'(MSG_VERSION));
    chk(32'(disp_data), 32'(VERS));
    wt(15);
    chk(32'(disp_msg), 32'(MSG_IDLE));
    apb(1'b0, OFF_VERSION, 32'h0);
    chk(rd_q, 32'(VERS));
    apb(1'b0, OFF_CTRL, 32'h0);
    chk(rd_q, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk({rd_q[31:1], err_q}, 32'h1);
    @(posedge clk);
    bus_hi <= 1'b0;
    wt(3);
    chk(32'(disp_msg), 32'(MSG_BUS_LOW));
    chk(32'(bus_ready), 32'h0);
    apb(1'b1, OFF_CTRL, 32'h1);
    wt(3);
    chk(32'(bus_ready), 32'h1);
    chk(32'(disp_msg), 32'(MSG_IDLE));
    @(posedge clk);
    drive_en <= 1'b1;
    wt(3);
    chk(32'(disp_msg), 32'(MSG_RUN));
    @(posedge clk);
    drive_en <= 1'b0;
    bus_hi <= 1'b1;
    apb(1'b1, OFF_CTRL, 32'h0);
    for (int i = 1; i < NPARAM; i++) key(1);
    for (int i = 1; i < NPARAM - 1; i++) key(2);
    apb(1'b1, OFF_VALUE, 32'h0fff);
    m_val[1] = 32'h0fff;
    key(0);
    key(1);
    key(2);
    rnd = lfsr(rnd);
    apb(1'b1, OFF_VALUE, {20'h0, rnd[11:0]});
    apb(1'b0, OFF_VALUE, 32'h0);
    chk(rd_q, {20'h0, rnd[11:0]});
    apb(1'b1, OFF_VALUE, 32'h0);
    u_op.fast(1, 5 * RN);
    apb(1'b0, OFF_VALUE, 32'h0);
    chk(rd_q % 10, 32'h1);
    chk(32'(rd_q >= 21 && rd_q <= 81), 32'h1);
    m_val[1] = int'(rd_q);
    view_chk();
    key(0);
    key(1);
    apb(1'b1, OFF_VALUE, 32'h03e8);
    m_val[2] = 1000;
    key(0);
    key(1);
    key(2);
    key(0);
    for (int i = 2; i < 12; i++) key(1);
    apb(1'b1, OFF_VALUE, 32'h1);
    m_val[12] = 1;
    key(0);
    key(0);
    apb(1'b1, OFF_IRQ_EN, 32'h1);
    rnd = lfsr(rnd);
    @(posedge clk);
    alarm <= 1'b1;
    alarm_code <= rnd[7:0];
    wt(3);
    m_idx = 0;
    m_alarm = 1;
    chk(32'(disp_msg), 32'(MSG_ALARM));
    chk(32'(disp_data), {24'h0, rnd[7:0]});
    chk(32'(drive_dis), 32'h1);
    chk(32'(irq), 32'h1);
    view_chk();
    apb(1'b1, OFF_IRQ_EN, 32'h0);
    wt(2);
    chk(32'(irq), 32'h0);
    apb(1'b1, OFF_IRQ_EN, 32'h1);
    wt(2);
    chk(32'(irq), 32'h1);
    apb(1'b1, OFF_IRQ_CLR, 32'h1);
    wt(2);
    chk(32'(irq), 32'h0);
    apb(1'b0, OFF_IRQ_STAT, 32'h0);
    chk(32'(rd_q[0]), 32'h0);
    apb(1'b1, OFF_CTRL, 32'h2);
    apb(1'b1, OFF_CMD, 32'h2);
    wt(3);
    chk(32'(disp_msg), 32'(MSG_ALARM));
    apb(1'b1, OFF_CTRL, 32'h0);
    @(posedge clk);
    alarm <= 1'b0;
    wt(3);
    chk(32'(disp_msg), 32'(MSG_ALARM));
    apb(1'b1, OFF_CMD, 32'h1);
    cnt = 0;
    repeat (4)
    begin
      @(negedge clk);
      if (alarm_clr === 1'b1) cnt++;
    end
    chk(32'(cnt), 32'h1);
    chk(32'(disp_msg), 32'(MSG_RESET));
    chk(32'(drive_dis), 32'h0);
    m_alarm = 0;
    wt(AN);
    chk(32'(disp_msg), 32'(MSG_IDLE));
    for (int b = 1; b < 4; b++)
    begin
      apb(1'b1, OFF_CMD, 32'(1 << b));
      wt(AN - 10);
      chk(32'(disp_msg), 32'(MSG_DONE));
      wt(15);
      chk(32'(disp_msg), 32'(MSG_IDLE));
    end
    @(posedge clk);
    store_err <= 1'b1;
    wt(3);
    chk(32'(disp_msg), 32'(MSG_RETRY));
    @(posedge clk);
    store_err <= 1'b0;
    wt(AN + 5);
    chk(32'(disp_msg), 32'(MSG_RETRY));
    apb(1'b1, OFF_CMD, 32'h4);
    wt(2);
    chk(32'(disp_msg), 32'(MSG_DONE));
    wt(AN);
    apb(1'b1, OFF_CTRL, 32'h2);
    wt(AN + 5);
    chk(32'(disp_msg), 32'(MSG_TEST));
    apb(1'b1, OFF_CTRL, 32'h0);
    wt(2);
    chk(32'(disp_msg), 32'(MSG_IDLE));
    report_and_stop();
  end
endmodule
`default_nettype wire
